// ==== tcm_monitor.v ====
// Contract
// - In anti-tamper mode compare live and neutral active energies.
// - Criterion: |A-B| above fraction of mean; select bit picks 12.5% or 6.25%.
// - Opposite signs mean tamper always, yet larger power channel chosen.
// - Line band error, stuck stream or no load disable logic, force normal.
// - After reset: normal state, primary channel for final integration.
// - Checking windows last sixty-four line periods.
// - At period 24 select secondary and freeze primary values.
// - Next sixteen periods final energy uses the frozen values.
// - Four periods after freeze, integrate secondary sample for four periods.
// - Four periods later return to primary and integrate primary sample.
// - From both samples evaluate criterion and pick higher current channel.
// - Tamper state entered only after four consecutive criterion results.
// - In tamper the multiplex ratio is 56:8 or 8:56 by larger energy.
// - Status flag reads one while tamper detected, zero otherwise.
// - In standalone mode tamper flag also drives the serial output pin.
// - Line periods are delimited by falling edges of the line trend.
// - No-load flag suspends integration and disables tamper logic.
// - Channel select status reads one for secondary, zero for primary.
//
// The register addresses and the APB interface to the registers were decided locally.
`include "tcm_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module tcm_monitor #(
	parameter EW = 24
) (
	// APB
	input  wire          pclk,
	input  wire          presetn,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [11:0]   paddr,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata,
	output wire          pready,
	output wire          pslverr,
	// Front end
	input  wire          line_trend,
	input  wire          line_band_error,
	input  wire          stream_stuck,
	input  wire          no_load_flag,
	input  wire          power_valid,
	input  wire [EW-1:0] power_sample,
	// Outputs to datapath and pins
	output reg           secondary_channel_select,
	output reg           primary_value_freeze,
	output reg           final_use_secondary,
	output reg           integrate_enable,
	output reg           standalone_serial_out,
	output wire          irq
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
reg [1:0] trend_s_q;
reg [1:0] band_s_q;
reg [1:0] stuck_s_q;
reg [1:0] load_s_q;
reg       trend_prev_q;

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		trend_s_q    <= 2'h0;
		band_s_q     <= 2'h0;
		stuck_s_q    <= 2'h0;
		load_s_q     <= 2'h0;
		trend_prev_q <= 1'b0;
	end
	else
	begin
		trend_s_q    <= {trend_s_q[0], line_trend};
		band_s_q     <= {band_s_q[0], line_band_error};
		stuck_s_q    <= {stuck_s_q[0], stream_stuck};
		load_s_q     <= {load_s_q[0], no_load_flag};
		trend_prev_q <= trend_s_q[1];
	end
end

// Falling edge of the trend closes one line period
wire period_tick = trend_prev_q & ~trend_s_q[1];

////////////////////////////////////////////////////////////////////////////////
// Registers
reg  [7:0] ctrl_q;
reg  [3:0] irq_stat_q;
reg  [3:0] irq_en_q;
wire       wr_en = psel & penable & pwrite;
wire       enable_q = ctrl_q[`TCM_CTRL_ENABLE];
wire       disabled = band_s_q[1] | stuck_s_q[1] | load_s_q[1] | ~enable_q;
wire       addr_ok = (paddr == `TCM_OFF_CTRL) | (paddr == `TCM_OFF_STATUS)
			| (paddr == `TCM_OFF_IRQ_STAT) | (paddr == `TCM_OFF_IRQ_EN)
			| (paddr == `TCM_OFF_IRQ_CLR) | (paddr == `TCM_OFF_ENERGY_A)
			| (paddr == `TCM_OFF_ENERGY_B);

assign pready  = 1'b1;
assign pslverr = psel & penable & ~addr_ok;
assign irq     = |(irq_stat_q & irq_en_q);

////////////////////////////////////////////////////////////////////////////////
// Tamper state
reg  [6:0]    win_cnt_q;
reg           tamper_q;
reg  [2:0]    consec_q;
reg  signed [EW+7:0] acc_q;
reg  signed [EW+7:0] samp_b_q;
reg  signed [EW+7:0] samp_a_q;
reg           eval_q;

// Phase decode in line periods within the window
wire [6:0] t_sel  = tamper_q ? `TCM_T_TAMP_SHORT : (`TCM_T_SAMPLE_AEND - `TCM_T_FREEZE);
wire       in_gap = (win_cnt_q >= `TCM_T_FREEZE) &&
			(win_cnt_q < `TCM_T_FREEZE + t_sel);
wire       in_b   = (win_cnt_q >= `TCM_T_SAMPLE_B) && (win_cnt_q < `TCM_T_SAMPLE_BEND);
wire       in_a   = (win_cnt_q >= `TCM_T_SAMPLE_A) && (win_cnt_q < `TCM_T_SAMPLE_AEND);

// Criterion on the two samples
wire signed [EW+8:0] diff  = {samp_a_q[EW+7], samp_a_q} - {samp_b_q[EW+7], samp_b_q};
wire signed [EW+8:0] sum   = {samp_a_q[EW+7], samp_a_q} + {samp_b_q[EW+7], samp_b_q};
wire        [EW+8:0] adiff = diff[EW+8] ? -diff : diff;
wire        [EW+8:0] asum  = sum[EW+8] ? -sum : sum;
// Fraction of mean: 1/16 or 1/32 of the sum
wire        [EW+8:0] lim   = ctrl_q[`TCM_CTRL_THRESH] ? (asum >> 5) : (asum >> 4);
wire        opp     = samp_a_q[EW+7] ^ samp_b_q[EW+7];
wire        tamper_threshold_select    = opp | (adiff > lim);
wire [EW+7:0] mag_a = samp_a_q[EW+7] ? -samp_a_q : samp_a_q;
wire [EW+7:0] mag_b = samp_b_q[EW+7] ? -samp_b_q : samp_b_q;
// Sample A is the channel in final use, B the other one
wire        other_bigger = mag_b > mag_a;

////////////////////////////////////////////////////////////////////////////////
// Result decode
// Tamper is taken on the fourth result in a row, or kept while already in it
wire       take_tamper = tamper_threshold_select & ((consec_q == `TCM_CONSEC_NEED - 3'd1) | tamper_q);
// Swap only on a tamper result and only toward the larger channel
wire       swap_now    = eval_q & take_tamper & other_bigger;
// Final channel after this edge; the select outputs follow it in the same edge,
// so modulator and final integrator never disagree outside the gap
wire       final_next  = ~disabled & (final_use_secondary ^ swap_now);
// Sample slot strobes at the end of the last period of a slot
wire       close_b     = period_tick & (win_cnt_q == `TCM_T_SAMPLE_BEND - 7'd1);
wire       close_a     = period_tick & (win_cnt_q == `TCM_T_SAMPLE_AEND - 7'd1);
// Window counter wraps every 64 line periods
wire [6:0] win_cnt_d   = (win_cnt_q == `TCM_WIN_LEN - 7'd1) ? 7'h00 : win_cnt_q + 7'd1;

////////////////////////////////////////////////////////////////////////////////
// Window counter, restarted while the logic is disabled
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		win_cnt_q <= 7'h00;
	else if (disabled)
		win_cnt_q <= 7'h00;
	else if (period_tick)
		win_cnt_q <= win_cnt_d;
end

////////////////////////////////////////////////////////////////////////////////
// Accumulator and the two tamper samples
// A power sample on the closing edge is dropped; the loss is one part in forty
// and falls on both samples alike, so the criterion is not biased
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		acc_q    <= {(EW+8){1'b0}};
		samp_b_q <= {(EW+8){1'b0}};
		samp_a_q <= {(EW+8){1'b0}};
	end
	else if (disabled)
		acc_q <= {(EW+8){1'b0}};
	else if (close_b)
	begin
		samp_b_q <= acc_q;
		acc_q    <= {(EW+8){1'b0}};
	end
	else if (close_a)
	begin
		samp_a_q <= acc_q;
		acc_q    <= {(EW+8){1'b0}};
	end
	else if (power_valid && (in_a || in_b))
		acc_q <= acc_q + {{8{power_sample[EW-1]}}, power_sample};
end

////////////////////////////////////////////////////////////////////////////////
// Result strobe and tamper decision
// The samples keep their last values while disabled, so a read still shows them
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		eval_q              <= 1'b0;
		tamper_q            <= 1'b0;
		consec_q            <= 3'h0;
		final_use_secondary <= 1'b0;
	end
	else if (disabled)
	begin
		eval_q              <= 1'b0;
		tamper_q            <= 1'b0;
		consec_q            <= 3'h0;
		final_use_secondary <= 1'b0;
	end
	else
	begin
		// Pair complete one clock after the primary sample closes
		eval_q              <= close_a;
		final_use_secondary <= final_next;
		if (eval_q)
		begin
			if (tamper_threshold_select)
			begin
				if (take_tamper)
					tamper_q <= 1'b1;
				// Saturate so a long tamper run cannot wrap back to zero
				if (consec_q != `TCM_CONSEC_NEED)
					consec_q <= consec_q + 3'd1;
			end
			else
			begin
				// First clean result leaves tamper
				consec_q <= 3'h0;
				tamper_q <= 1'b0;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Select and freeze outputs, mirrored when secondary is in final use
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		secondary_channel_select <= 1'b0;
		primary_value_freeze     <= 1'b0;
	end
	else
	begin
		// Other channel routed to the modulator during the gap until the primary sample slot, final one otherwise
		secondary_channel_select <= ~disabled & (final_next ^ (in_gap & ~in_a));
		primary_value_freeze     <= ~disabled & in_gap;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Integration gate and standalone pin
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		integrate_enable      <= 1'b0;
		standalone_serial_out <= 1'b0;
	end
	else
	begin
		// No load stops integration at once, independent of the enable bit
		integrate_enable      <= ~load_s_q[1];
		standalone_serial_out <= ctrl_q[`TCM_CTRL_STANDA] & tamper_q;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Register writes and event capture
reg        tamper_prev_q;
reg        sel_prev_q;
// Write strobes, one per writable register, taken in the access phase
wire       wr_ctrl   = wr_en & (paddr == `TCM_OFF_CTRL);
wire       wr_irq_en = wr_en & (paddr == `TCM_OFF_IRQ_EN);
wire       wr_clr    = wr_en & (paddr == `TCM_OFF_IRQ_CLR);
// Event strobes, one clock each
wire       ev_enter  = ~tamper_prev_q & tamper_q;
wire       ev_leave  = tamper_prev_q & ~tamper_q;
wire       ev_swap   = final_use_secondary ^ sel_prev_q;
wire [3:0] events    = {ev_swap, eval_q, ev_leave, ev_enter};
wire [3:0] clr       = wr_clr ? pwdata[3:0] : 4'h0;

// Control and interrupt enable registers
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		ctrl_q   <= `TCM_CTRL_RESET;
		irq_en_q <= 4'h0;
	end
	else
	begin
		if (wr_ctrl)
			ctrl_q <= pwdata[7:0];
		if (wr_irq_en)
			irq_en_q <= pwdata[3:0];
	end
end

// Edge history for the event strobes
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		tamper_prev_q <= 1'b0;
		sel_prev_q    <= 1'b0;
	end
	else
	begin
		tamper_prev_q <= tamper_q;
		sel_prev_q    <= final_use_secondary;
	end
end

// Sticky status; an event in the clearing cycle survives the clear
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		irq_stat_q <= 4'h0;
	else
		irq_stat_q <= (irq_stat_q & ~clr) | events;
end

////////////////////////////////////////////////////////////////////////////////
// Read mux, registered data at the access phase
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		prdata <= 32'h0;
	else if (psel && !penable && !pwrite)
	begin
		case (paddr)
		`TCM_OFF_CTRL:     prdata <= {24'h0, ctrl_q};
		`TCM_OFF_STATUS:   prdata <= {28'h0, disabled, primary_value_freeze,
					final_use_secondary, tamper_q};
		`TCM_OFF_IRQ_STAT: prdata <= {28'h0, irq_stat_q};
		`TCM_OFF_IRQ_EN:   prdata <= {28'h0, irq_en_q};
		`TCM_OFF_ENERGY_A: prdata <= samp_a_q[31:0];
		`TCM_OFF_ENERGY_B: prdata <= samp_b_q[31:0];
		default:           prdata <= 32'h0;
		endcase
	end
end

endmodule
`default_nettype wire

// ==== tcm_defines.vh ====
`ifndef TCM_DEFINES_VH
`define TCM_DEFINES_VH

// Register byte offsets
`define TCM_OFF_CTRL      12'h000
`define TCM_OFF_STATUS    12'h004
`define TCM_OFF_IRQ_STAT  12'h008
`define TCM_OFF_IRQ_EN    12'h00C
`define TCM_OFF_IRQ_CLR   12'h010
`define TCM_OFF_ENERGY_A  12'h014
`define TCM_OFF_ENERGY_B  12'h018

// Control fields
`define TCM_CTRL_ENABLE   0
`define TCM_CTRL_THRESH   1
`define TCM_CTRL_STANDA   2
`define TCM_CTRL_RESET    8'h00

// Status fields
`define TCM_ST_TAMPER     0
`define TCM_ST_SECONDARY  1
`define TCM_ST_FREEZE     2
`define TCM_ST_DISABLED   3

// Interrupt event bits
`define TCM_EV_ENTER      0
`define TCM_EV_LEAVE      1
`define TCM_EV_RESULT     2
`define TCM_EV_SWAP       3

// Window timing in line periods
`define TCM_WIN_LEN       7'd64
`define TCM_T_FREEZE      7'd24
`define TCM_T_SAMPLE_B    7'd28
`define TCM_T_SAMPLE_BEND 7'd32
`define TCM_T_SAMPLE_A    7'd36
`define TCM_T_SAMPLE_AEND 7'd40
`define TCM_T_TAMP_SHORT  7'd8
`define TCM_CONSEC_NEED   3'd4

`endif

// ==== tcm_front_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcm_front_model #(
	parameter int PER = 40
) (
	// Clock and channel select
	input  wire logic        pclk,
	input  wire logic        sel,
	// Channel powers
	input  wire logic [23:0] pa,
	input  wire logic [23:0] pb,
	// Trend and power stream
	output var  logic        line_trend = 1'h0,
	output var  logic        power_valid = 1'h0,
	output var  logic [23:0] power_sample = 24'h000000
);
	int cnt = 0;
	// Trend falls once a period, samples every fourth cycle, junk between
	always @(posedge pclk)
	begin
		cnt <= (cnt + 1) % PER;
		line_trend <= (cnt >= PER / 2);
		power_valid <= (cnt % 4 == 0);
		power_sample <= (cnt % 4 == 0) ? (sel ? pb : pa) : ~power_sample;
	end
endmodule
`default_nettype wire

// ==== tcm_monitor_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcm_monitor_chk (
	// Bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pslverr,
	// Tamper side
	input wire logic        no_load_flag,
	input wire logic        secondary_channel_select,
	input wire logic        primary_value_freeze,
	input wire logic        final_use_secondary,
	input wire logic        integrate_enable,
	input wire logic        standalone_serial_out
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Channel sequencing
	a_reset_idle: assert property ($rose(presetn) |->
		!(final_use_secondary | secondary_channel_select | primary_value_freeze))
		else $error("outputs active after reset");
	a_freeze_flips: assert property ($rose(primary_value_freeze) |->
		secondary_channel_select != final_use_secondary) else $error("no swap at freeze");
	a_freeze_holds: assert property ($rose(primary_value_freeze) |=>
		primary_value_freeze[*8]) else $error("freeze too short");
	a_mux_in_gap: assert property (secondary_channel_select != final_use_secondary |->
		primary_value_freeze) else $error("swap outside freeze");
	a_final_after: assert property ($changed(final_use_secondary) |->
		!primary_value_freeze) else $error("final changed in gap");
	// Disable conditions and bus error
	a_noload_hold: assert property (no_load_flag[*8] |->
		!integrate_enable && !primary_value_freeze) else $error("no load ignored");
	a_noload_normal: assert property (no_load_flag[*8] |->
		!(final_use_secondary | standalone_serial_out | secondary_channel_select))
		else $error("not forced normal");
	a_bus_error: assert property (psel && penable && paddr > 12'h018 |-> pslverr)
		else $error("unmapped without error");
endmodule
bind tcm_monitor tcm_monitor_chk i_tcm_monitor_chk (.*);
`default_nettype wire

// ==== tb_tamper_channel_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_tamper_channel_monitor;
	localparam int PER = 40;
	// Stimulus
	logic        pclk = 1'h0;
	logic        presetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        line_band_error = 1'h0;
	logic        stream_stuck = 1'h0;
	logic        no_load_flag = 1'h0;
	logic [23:0] pa = 24'h0003E8;
	logic [23:0] pb = 24'h0003E8;
	// Observed
	wire  [31:0] prdata;
	wire  [23:0] power_sample;
	wire         pready, pslverr, line_trend, power_valid, integrate_enable;
	wire         standalone_serial_out, irq;
	logic        sel, frz, fin, er;
	logic [31:0] rd;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          t0;
	tcm_monitor i_tcm_monitor (.*, .secondary_channel_select(sel), .primary_value_freeze(frz),
		.final_use_secondary(fin));
	tcm_front_model #(.PER(PER)) i_tcm_front_model (.*);
	// Clock and cycle count
	initial forever #10 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
	begin
		checks_done++;
		if (got !== ex)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	end
	endtask
	// One transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
	begin
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	end
	endtask
	// Waits on a level, the watchdog cuts a hang
	task automatic wt(ref logic s, input logic v);
	begin
		while (s !== v)
			@(posedge pclk);
	end
	endtask
	task automatic final_report;
	begin
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	// Test sequence
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk("idle", 32'h0, {fin, sel, frz, standalone_serial_out, irq});
		apb(1'h0, 12'h01C, 32'h0);
		chk("unmapped", 32'h1, er);
		apb(1'h1, 12'h00C, 32'h1);
		apb(1'h1, 12'h000, 32'h5);
		wt(frz, 1'h1);
		t0 = cyc;
		chk("select", 32'h1, sel);
		wt(sel, 1'h0);
		chk("select back", 12 * PER, cyc - t0);
		wt(frz, 1'h0);
		chk("freeze span", 16 * PER, cyc - t0);
		wt(frz, 1'h1);
		chk("window", 64 * PER, cyc - t0);
		pb <= 24'h000BB8;
		for (int i = 1; i <= 4; i++)
		begin
			wt(frz, 1'h0);
			repeat (3) @(posedge pclk);
			apb(1'h0, 12'h004, 32'h0);
			chk("entry", (i == 4) ? 32'h3 : 32'h0, rd[1:0]);
			wt(frz, 1'h1);
		end
		t0 = cyc;
		chk("mirror", 32'h0, sel);
		wt(frz, 1'h0);
		chk("gap", 8 * PER, cyc - t0);
		chk("serial irq", 32'h3, {standalone_serial_out, irq});
		apb(1'h1, 12'h010, 32'h1);
		chk("irq clear", 32'h0, irq);
		pb <= 24'hFFFE0C;
		wt(frz, 1'h1);
		wt(frz, 1'h0);
		wt(frz, 1'h1);
		apb(1'h0, 12'h004, 32'h0);
		chk("signs", 32'h1, rd[1:0]);
		no_load_flag <= 1'h1;
		repeat (10) @(posedge pclk);
		apb(1'h0, 12'h004, 32'h0);
		chk("no load", 32'h0, {integrate_enable, fin, frz, rd[0]});
		no_load_flag <= 1'h0;
		pb <= 24'h00044C;
		apb(1'h1, 12'h000, 32'h7);
		repeat (4)
		begin
			wt(frz, 1'h1);
			wt(frz, 1'h0);
		end
		repeat (3) @(posedge pclk);
		apb(1'h0, 12'h004, 32'h0);
		chk("fine", 32'h3, rd[1:0]);
		apb(1'h1, 12'h000, 32'h5);
		wt(frz, 1'h1);
		wt(frz, 1'h0);
		wt(frz, 1'h1);
		apb(1'h0, 12'h004, 32'h0);
		chk("coarse", 32'h0, rd[0]);
		final_report();
	end
	// Watchdog
	initial
	begin
		repeat (80000) @(posedge pclk);
		error_cnt++;
		final_report();
	end
endmodule
`default_nettype wire
